// [logic/dpt_pkg.sv]
// package of constants for the data page translation block
package dpt_pkg;
    localparam int PAGE_W = 10;
    localparam int EA_W   = 16;
    localparam int XA_W   = PAGE_W + EA_W - 1;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h0001;
    localparam logic [PAGE_W-1:0] PAGE_ZERO  = 10'h0000;
    localparam int EA_MSB = 15;
    localparam int ADDR_ERROR_BIT = 3;
    localparam int TRAP_W = 16;
    // register byte addresses on the bus
    localparam logic [7:0] RPAG_ADDR  = 8'h00;
    localparam logic [7:0] WPAG_ADDR  = 8'h04;
    localparam logic [7:0] TRAP_ADDR  = 8'h08;
    localparam logic [7:0] MASK_ADDR  = 8'h0C;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : dpt_pkg

// [logic/dpt_top.sv]
// data page translation with page registers and address error trap
//
// Behaviour
// - lower half addresses translate regardless of page register contents
// - lower half reachable for indirect as well as direct accesses
// - effective_address_msb zero maps to extended page 0, 0x000000-0x007FFF
// - page 0 never reached via upper window when page select is zero
// - reset loads read and write page selects with one
// - upper window access with zero page raises address error trap
// - software writes of zero to a page select are ignored
// - nonzero pages reached only via upper window with msb one
// - page n upper window maps to extended block n
// - address error sets bit 3 of trap status; zero otherwise
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module dpt_top
    import dpt_pkg::*;
(
    // clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_reset,
    // core access (indirect flag only tagged, same path)
    input  wire logic                 i_acc_valid,
    input  wire logic                 i_acc_write,
    input  wire logic                 i_acc_indirect,
    input  wire logic [dpt_pkg::EA_W-1:0] i_acc_ea,
    // translated access
    output logic                      o_xacc_valid,
    output logic                      o_xacc_write,
    output logic [dpt_pkg::XA_W-1:0]  o_xacc_addr,
    output logic                      o_addr_error_trap,
    // ahb-lite slave
    input  wire logic                 i_hsel,
    input  wire logic [31:0]          i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic [31:0]               o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    // interrupt
    output logic                      o_irq
);
    import dpt_pkg::*;

    logic [PAGE_W-1:0] read_page_select_q;
    logic [PAGE_W-1:0] write_page_select_q;
    logic [TRAP_W-1:0] trap_status_q;
    logic [TRAP_W-1:0] mask_q;
    logic              wr_pend_q;
    logic [7:0]        wr_addr_q;
    logic              rd_pend_q;
    logic [7:0]        rd_addr_q;
    logic [31:0]       rd_data;
    logic              bus_ok;
    logic              trap_set;
    logic              trap_clr;
    logic [PAGE_W-1:0] data_page_select;
    logic              upper_win;

    function automatic logic [XA_W-1:0] xlate(
        input logic [PAGE_W-1:0] page,
        input logic [EA_W-1:0]   ea
    );
        logic [XA_W-1:0] r;
        r = {XA_W{1'b0}};
        if (ea[EA_MSB])
            r = {page, ea[EA_MSB-1:0]};
        else
            r = {{PAGE_W{1'b0}}, ea[EA_MSB-1:0]};
        return r;
    endfunction : xlate

    assign upper_win = i_acc_ea[EA_MSB];
    // reads use the read page, writes the write page
    assign data_page_select = i_acc_write ? write_page_select_q
                                          : read_page_select_q;
    assign trap_set = i_acc_valid && upper_win
                      && (data_page_select == PAGE_ZERO);

    // translated access is registered; a trapped access is dropped
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_xacc_valid <= 1'b0;
            o_xacc_write <= 1'b0;
            o_xacc_addr  <= {XA_W{1'b0}};
            o_addr_error_trap <= 1'b0;
        end else begin
            o_xacc_valid <= i_acc_valid && !trap_set;
            o_xacc_write <= i_acc_write;
            o_xacc_addr  <= xlate(data_page_select, i_acc_ea);
            o_addr_error_trap <= trap_set;
        end
    end

    // ahb-lite: zero wait states, always okay
    assign bus_ok = i_hsel && i_hready
                    && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= bus_ok && i_hwrite;
            rd_pend_q <= bus_ok && !i_hwrite;
            if (bus_ok) begin
                wr_addr_q <= i_haddr[7:0];
                rd_addr_q <= i_haddr[7:0];
            end
        end
    end

    // page registers: a zero write leaves the old page in place
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            read_page_select_q  <= PAGE_RESET;
            write_page_select_q <= PAGE_RESET;
        end else if (wr_pend_q) begin
            if (wr_addr_q == RPAG_ADDR
                && i_hwdata[PAGE_W-1:0] != PAGE_ZERO)
                read_page_select_q <= i_hwdata[PAGE_W-1:0];
            if (wr_addr_q == WPAG_ADDR
                && i_hwdata[PAGE_W-1:0] != PAGE_ZERO)
                write_page_select_q <= i_hwdata[PAGE_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset)
            mask_q <= {TRAP_W{1'b0}};
        else if (wr_pend_q && wr_addr_q == MASK_ADDR)
            mask_q <= i_hwdata[TRAP_W-1:0];
    end

    // read of trap status clears it; a same-cycle trap still sets
    assign trap_clr = bus_ok && !i_hwrite && i_haddr[7:0] == TRAP_ADDR;
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            trap_status_q <= {TRAP_W{1'b0}};
        end else begin
            if (trap_clr)
                trap_status_q <= {TRAP_W{1'b0}};
            if (trap_set)
                trap_status_q[ADDR_ERROR_BIT] <= 1'b1;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr_q)
            RPAG_ADDR: rd_data[PAGE_W-1:0] = read_page_select_q;
            WPAG_ADDR: rd_data[PAGE_W-1:0] = write_page_select_q;
            TRAP_ADDR: rd_data[TRAP_W-1:0] = trap_status_q;
            MASK_ADDR: rd_data[TRAP_W-1:0] = mask_q;
            default:   rd_data = 32'h0000_0000;
        endcase
    end

    // status is cleared in the address phase, so the value is latched then
    logic [TRAP_W-1:0] trap_snap_q;
    always_ff @(posedge i_core_clk) begin
        if (i_reset)
            trap_snap_q <= {TRAP_W{1'b0}};
        else if (trap_clr)
            trap_snap_q <= trap_status_q;
    end

    always_comb begin
        o_hrdata = 32'h0000_0000;
        if (rd_pend_q)
            o_hrdata = (rd_addr_q == TRAP_ADDR)
                       ? {16'h0000, trap_snap_q} : rd_data;
    end

    assign o_irq = |(trap_status_q & mask_q);

    // assertions
    // the trap path cannot be reached from the bus: reset loads one and zero
    // writes are dropped, so the trap checks guard against upset registers
    sequence lower_req_s;
        i_acc_valid && !i_acc_ea[EA_MSB];
    endsequence : lower_req_s
    sequence upper_req_s;
        i_acc_valid && i_acc_ea[EA_MSB] && !trap_set;
    endsequence : upper_req_s
    sequence xacc_out_s;
        o_xacc_valid && !o_addr_error_trap;
    endsequence : xacc_out_s
    sequence trap_out_s;
        o_addr_error_trap && !o_xacc_valid;
    endsequence : trap_out_s
    sequence page_wr_s;
        wr_pend_q && i_hwdata[PAGE_W-1:0] != PAGE_ZERO;
    endsequence : page_wr_s
    sequence zero_wr_s;
        wr_pend_q && i_hwdata[PAGE_W-1:0] == PAGE_ZERO;
    endsequence : zero_wr_s

    // core side
    zero_page_trap_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_set |=> trap_out_s ##0 trap_status_q[ADDR_ERROR_BIT])
        else $error("zero page access did not trap");

    lower_map_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        lower_req_s |=> xacc_out_s ##0
        (o_xacc_addr == {{PAGE_W{1'b0}}, $past(i_acc_ea[EA_MSB-1:0])}))
        else $error("lower half not mapped to page 0");

    upper_map_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        upper_req_s |=> xacc_out_s ##0
        (o_xacc_addr[XA_W-1:EA_MSB] == $past(data_page_select))
        ##0 (o_xacc_addr[XA_W-1:EA_MSB] != PAGE_ZERO))
        else $error("upper window mapping wrong");

    lower_any_page_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        lower_req_s |=> o_xacc_addr[XA_W-1:EA_MSB] == PAGE_ZERO)
        else $error("lower half depends on page select");

    indirect_same_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        lower_req_s ##0 i_acc_indirect |=> xacc_out_s ##0
        (o_xacc_addr[XA_W-1:EA_MSB] == PAGE_ZERO))
        else $error("indirect lower access not on page 0");

    nonzero_upper_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        o_xacc_valid && o_xacc_addr[XA_W-1:EA_MSB] != PAGE_ZERO
        |-> $past(i_acc_ea[EA_MSB]))
        else $error("nonzero page reached from lower half");

    write_dir_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        i_acc_valid && !trap_set |=> o_xacc_write == $past(i_acc_write))
        else $error("translated access lost its direction");

    read_page_use_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        upper_req_s ##0 (!i_acc_write)
        |=> o_xacc_addr[XA_W-1:EA_MSB] == $past(read_page_select_q))
        else $error("read did not use the read page");

    write_page_use_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        upper_req_s ##0 (i_acc_write)
        |=> o_xacc_addr[XA_W-1:EA_MSB] == $past(write_page_select_q))
        else $error("write did not use the write page");

    trap_pulse_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        o_addr_error_trap |-> $past(trap_set))
        else $error("trap pulse without a zero page access");

    // bus and register side
    page_nonzero_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        read_page_select_q != PAGE_ZERO
        && write_page_select_q != PAGE_ZERO)
        else $error("page select became zero");

    zero_write_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        zero_wr_s ##0 (wr_addr_q == RPAG_ADDR)
        |=> $stable(read_page_select_q))
        else $error("zero write changed read page");

    zero_wpage_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        zero_wr_s ##0 (wr_addr_q == WPAG_ADDR)
        |=> $stable(write_page_select_q))
        else $error("zero write changed write page");

    page_load_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        page_wr_s ##0 (wr_addr_q == WPAG_ADDR)
        |=> write_page_select_q == $past(i_hwdata[PAGE_W-1:0]))
        else $error("nonzero write did not load the write page");

    rd_page_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        rd_pend_q && rd_addr_q == RPAG_ADDR
        |-> o_hrdata == {{(32-PAGE_W){1'b0}}, read_page_select_q})
        else $error("read page not returned on the bus");

    reset_page_a: assert property (@(posedge i_core_clk)
        $fell(i_reset) |-> read_page_select_q == PAGE_RESET
        && write_page_select_q == PAGE_RESET)
        else $error("page select not one after reset");

    // trap status and interrupt
    reset_clear_a: assert property (@(posedge i_core_clk)
        $fell(i_reset) |-> trap_status_q == {TRAP_W{1'b0}}
        && !o_xacc_valid && !o_addr_error_trap)
        else $error("status or outputs not clear after reset");

    no_spurious_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        !trap_set && !trap_status_q[ADDR_ERROR_BIT]
        |=> !trap_status_q[ADDR_ERROR_BIT])
        else $error("address error set without trap");

    status_sticky_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_status_q[ADDR_ERROR_BIT] && !trap_clr
        |=> trap_status_q[ADDR_ERROR_BIT])
        else $error("address error flag lost without a read");

    read_clear_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_clr && !trap_set |=> trap_status_q == {TRAP_W{1'b0}})
        else $error("status read did not clear the flags");

    set_wins_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_clr && trap_set |=> trap_status_q[ADDR_ERROR_BIT])
        else $error("clear beat a same-cycle trap");

    snap_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_clr |=> trap_snap_q == $past(trap_status_q))
        else $error("status snapshot not taken before clear");

    irq_level_a: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        trap_set && mask_q[ADDR_ERROR_BIT]
        && !(wr_pend_q && wr_addr_q == MASK_ADDR) |=> o_irq)
        else $error("masked-in trap gave no interrupt");
endmodule : dpt_top

// [dv/dpt_core_model.sv]
// processor core model issuing single data accesses
`timescale 1ns/1ps
module dpt_core_model
    import dpt_pkg::*;
(
    // clock
    input  wire logic                     i_core_clk,
    // data access towards the block
    output logic                          o_acc_valid,
    output logic                          o_acc_write,
    output logic                          o_acc_indirect,
    output logic [dpt_pkg::EA_W-1:0]      o_acc_ea
);
    initial begin
        o_acc_valid = 1'b0;
        o_acc_write = 1'b0;
        o_acc_indirect = 1'b0;
        o_acc_ea = 16'h0000;
    end
    // gap lets the core issue promptly or after idle cycles
    task automatic access(input logic wr, input logic [EA_W-1:0] ea,
                          input int gap);
        repeat (gap) @(posedge i_core_clk);
        @(posedge i_core_clk);
        o_acc_valid <= 1'b1;
        o_acc_write <= wr;
        o_acc_ea <= ea;
        // alternate direct and indirect forms
        o_acc_indirect <= ~o_acc_indirect;
        @(posedge i_core_clk);
        o_acc_valid <= 1'b0;
        o_acc_ea <= ~ea;
    endtask : access
endmodule : dpt_core_model

// [dv/data_page_translation_tb.sv]
// self-checking bench for the data page translation block
`timescale 1ns/1ps
module data_page_translation_tb;
    import dpt_pkg::*;
    typedef struct packed {
        logic [PAGE_W-1:0] rp;
        logic [PAGE_W-1:0] wp;
        logic              wr;
        logic [EA_W-1:0]   ea;
        logic [XA_W-1:0]   xa;
    } dpt_row_t;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdy;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [31:0] hr_q, rd;
    logic hy_q, hresp, irq, av, aw, ai, xv, xw, trap;
    logic [EA_W-1:0] aea;
    logic [XA_W-1:0] xa;
    int mismatches = 0, compares = 0;
    dpt_row_t rows [8] = '{
        '{10'h001, 10'h001, 1'b0, 16'h0000, 25'h000_0000},
        '{10'h001, 10'h001, 1'b0, 16'h7FFF, 25'h000_7FFF},
        '{10'h001, 10'h001, 1'b0, 16'h8000, 25'h000_8000},
        '{10'h002, 10'h001, 1'b0, 16'hFFFF, 25'h001_7FFF},
        '{10'h002, 10'h001, 1'b0, 16'h0010, 25'h000_0010},
        '{10'h002, 10'h003, 1'b1, 16'h8000, 25'h001_8000},
        '{10'h3FF, 10'h3FF, 1'b1, 16'h8001, 25'h1FF_8001},
        '{10'h002, 10'h003, 1'b1, 16'h7000, 25'h000_7000}};
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        hr_q <= hrdata;
        hy_q <= rdy;
    end
    dpt_core_model core_u (.i_core_clk(clk), .o_acc_valid(av),
        .o_acc_write(aw), .o_acc_indirect(ai), .o_acc_ea(aea));
    dpt_top dut_u (.i_core_clk(clk), .i_reset(rst), .i_acc_valid(av),
        .i_acc_write(aw), .i_acc_indirect(ai), .i_acc_ea(aea),
        .o_xacc_valid(xv), .o_xacc_write(xw), .o_xacc_addr(xa),
        .o_addr_error_trap(trap), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
        .o_hreadyout(rdy), .o_hresp(hresp), .o_irq(irq));
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (hy_q !== 1'b1 && n < 50);
        if (n >= 50) check("hready", 32'h0, 32'h1);
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hr_q;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic results();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        #(25 * 4000);
        mismatches++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b1, RPAG_ADDR, {22'h0, rows[i].rp});
            bus(1'b1, WPAG_ADDR, {22'h0, rows[i].wp});
            core_u.access(rows[i].wr, rows[i].ea, i % 3);
            #1;
            check("xacc addr", {7'h0, xa}, {7'h0, rows[i].xa});
            check("xacc valid", {30'h0, xv, xw},
                  {30'h0, 1'b1, rows[i].wr});
            check("trap", {31'h0, trap}, 32'h0);
        end
        // zero and truncated-to-zero page writes must leave the page alone
        bus(1'b1, WPAG_ADDR, 32'h0000_0000);
        bus(1'b1, RPAG_ADDR, 32'h0000_0400);
        bus(1'b0, WPAG_ADDR, 32'h0);
        check("write page", rd, 32'h0000_0003);
        bus(1'b0, RPAG_ADDR, 32'h0);
        check("read page", rd, 32'h0000_0002);
        bus(1'b1, MASK_ADDR, 32'h0000_0008);
        bus(1'b0, MASK_ADDR, 32'h0);
        check("mask", rd, 32'h0000_0008);
        bus(1'b0, TRAP_ADDR, 32'h0);
        check("trap status", rd, 32'h0000_0000);
        check("irq", {31'h0, irq}, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, RPAG_ADDR, 32'h0);
        check("read page reset", rd, 32'h0000_0001);
        bus(1'b0, WPAG_ADDR, 32'h0);
        check("write page reset", rd, 32'h0000_0001);
        bus(1'b0, MASK_ADDR, 32'h0);
        check("mask reset", rd, 32'h0000_0000);
        check("irq reset", {31'h0, irq}, 32'h0);
        core_u.access(1'b0, 16'h8123, 0);
        #1;
        check("xacc after reset", {7'h0, xa}, 32'h0000_8123);
        results();
    end
endmodule : data_page_translation_tb
